// File: dv/bio_exec_assertions.sv
`timescale 1ns/10ps
module bio_exec_assertions #(
  parameter int CYCLE_CLKS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [12:0] progAddr,
  input wire logic [13:0] progData,
  input wire logic [7:0] programPageLatch,
  input wire logic [7:0] fileRdData,
  input wire bio_pkg::bio_file_write_t fileWrite,
  input wire logic [7:0] accumulator,
  input wire logic zeroFlag,
  input wire logic cycleTick,
  input wire bio_pkg::bio_events_t events
);
  logic [13:0] fetchWord;
  logic [13:0] execWord;
  logic [1:0] pageSeen;
  logic [7:0] fileSeen;
  logic [7:0] accSeen;
  wire logic [5:0] opc = execWord[13:8];
  // inputs as the execute stage saw them, held for the clock after the tick
  always_ff @(posedge clk) begin
    if (cycleTick) fetchWord <= progData;
    execWord <= fetchWord;
    pageSeen <= programPageLatch[4:3];
    fileSeen <= fileRdData;
    accSeen <= accumulator;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ran;
    events.executed && !events.bubble;
  endsequence
  sequence s_incr;
    s_ran ##0 (opc == bio_pkg::OPC_INC || opc == bio_pkg::OPC_INC_SKIP);
  endsequence
  a_jump_target: assert property (
    events.jumped |-> progAddr == {pageSeen, execWord[10:0]}) else $error("bad target");
  a_jump_bubble: assert property (
    events.jumped |-> ##CYCLE_CLKS events.bubble) else $error("jump not two cycles");
  a_skip_bubble: assert property (
    events.skipped |-> ##CYCLE_CLKS events.bubble) else $error("skip without no-op");
  a_skip_zero: assert property (
    s_ran ##0 (opc == bio_pkg::OPC_INC_SKIP) |-> events.skipped == (fileSeen == 8'hff))
    else $error("bad skip");
  a_inc_plain: assert property (
    s_ran ##0 (opc == bio_pkg::OPC_INC) |-> !events.skipped && zeroFlag == (fileSeen == 8'hff))
    else $error("bad increment");
  a_dest_file: assert property (
    s_incr ##0 execWord[7] |-> fileWrite.en && fileWrite.addr == execWord[6:0]
      && fileWrite.data == fileSeen + 8'h01) else $error("bad file write");
  a_dest_acc: assert property (
    s_incr ##0 !execWord[7] |-> !fileWrite.en && accumulator == fileSeen + 8'h01)
    else $error("bad accumulator write");
  a_or_lit: assert property (
    s_ran ##0 (opc == bio_pkg::OPC_OR_LIT) |-> accumulator == (accSeen | execWord[7:0])
      && zeroFlag == (accumulator == 8'h00)) else $error("bad or result");
endmodule : bio_exec_assertions

bind bio_exec bio_exec_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) u_bio_exec_assertions (
  .clk(clk), .reset(reset), .progAddr(progAddr), .progData(progData),
  .programPageLatch(programPageLatch), .fileRdData(fileRdData), .fileWrite(fileWrite),
  .accumulator(accumulator), .zeroFlag(zeroFlag), .cycleTick(cycleTick), .events(events));

// File: dv/test_branch_increment_or_exec.sv
`timescale 1ns/10ps
module test_branch_increment_or_exec;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] progData = 14'h0000;
  logic [7:0] programPageLatch = 8'h00;
  logic [7:0] fileRdData = 8'h00;
  logic [12:0] progAddr;
  logic [6:0] fileRdAddr;
  bio_pkg::bio_file_write_t fileWrite;
  logic [7:0] accumulator;
  logic zeroFlag;
  logic cycleTick;
  bio_pkg::bio_events_t events;
  logic [13:0] prog [16];
  logic [7:0] fileMem [128];
  int fails = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  bio_exec #(.CYCLE_CLKS(4)) u_bio_exec (.clk(clk), .reset(reset), .progAddr(progAddr),
    .progData(progData), .programPageLatch(programPageLatch), .fileRdAddr(fileRdAddr),
    .fileRdData(fileRdData), .fileWrite(fileWrite), .accumulator(accumulator),
    .zeroFlag(zeroFlag), .cycleTick(cycleTick), .events(events));
  // memories answer a clock late; safe only while a cycle spans at least three clocks
  always @(posedge clk) begin
    progData <= prog[progAddr[3:0]];
    fileRdData <= fileMem[fileRdAddr];
    if (fileWrite.en === 1'b1) fileMem[fileWrite.addr] <= fileWrite.data;
  end
  function automatic logic [13:0] orl(input logic [7:0] k);
    return {bio_pkg::OPC_OR_LIT, k};
  endfunction : orl
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic start(input logic [7:0] page, input logic [13:0] w0, w1, w2, w3, w4);
    prog = '{0: w0, 1: w1, 2: w2, 3: w3, 4: w4, default: 14'h0000};
    @(posedge clk);
    reset <= 1'b1;
    programPageLatch <= page;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
  endtask : start
  task automatic ticks(input int n);
    int t;
    t = 0;
    for (int i = 0; i < 100 && t < n; i++) begin
      @(negedge clk);
      if (cycleTick === 1'b1) t++;
    end
    if (t < n) begin
      fails++;
      complete_run();
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : ticks
  task automatic t_jump();
    start(8'hf7, {bio_pkg::OPC_JUMP, 11'h123}, orl(8'h01), 14'h0000, orl(8'h04), orl(8'h40));
    ticks(4);
    check(accumulator, 8'h04);
    check(progAddr, 13'h1125);
  endtask : t_jump
  task automatic t_skip();
    fileMem[5] = 8'hff;
    fileMem[6] = 8'h10;
    start(8'h00, {bio_pkg::OPC_INC_SKIP, 8'h85}, orl(8'h01), {bio_pkg::OPC_INC_SKIP, 8'h06},
      orl(8'h20), orl(8'h80));
    ticks(5);
    check(fileMem[5], 8'h00);
    check(fileMem[6], 8'h10);
    check(accumulator, 8'h31);
  endtask : t_skip
  task automatic t_inc();
    fileMem[7] = 8'hff;
    start(8'h00, {bio_pkg::OPC_INC, 8'h87}, orl(8'h08), {bio_pkg::OPC_INC, 8'h07},
      14'h0000, 14'h0000);
    ticks(2);
    check(fileMem[7], 8'h00);
    check(zeroFlag, 1'b1);
    ticks(1);
    check(accumulator, 8'h08);
    ticks(1);
    check(accumulator, 8'h01);
    check(zeroFlag, 1'b0);
  endtask : t_inc
  task automatic t_or();
    start(8'h00, orl(8'h00), orl(8'h9a), orl(8'h35), 14'h0000, 14'h0000);
    ticks(2);
    check({accumulator, 7'h00, zeroFlag}, 16'h0001);
    ticks(2);
    check({accumulator, 7'h00, zeroFlag}, 16'hbf00);
  endtask : t_or
  initial begin
    t_jump();
    t_skip();
    t_inc();
    t_or();
    complete_run();
  end
endmodule : test_branch_increment_or_exec

// File: rtl/bio_alu.sv
`timescale 1ns/10ps
module bio_alu (
  input bio_pkg::bio_op_t op,
  input logic [bio_pkg::DATA_W-1:0] fileData,
  input logic [bio_pkg::DATA_W-1:0] acc,
  input logic [bio_pkg::DATA_W-1:0] literal,
  output logic [bio_pkg::DATA_W-1:0] result,
  output logic isZero
);

  always_comb begin
    case (op)
      bio_pkg::BIO_OP_INC_SKIP,
      bio_pkg::BIO_OP_INC: begin
        // wraps from all ones to zero, which is what makes the skip fire
        result = fileData + 8'h01;
      end
      bio_pkg::BIO_OP_OR_LIT: begin
        result = acc | literal;
      end
      default: begin
        result = acc;
      end
    endcase
    isZero = (result == 8'h00);
  end

endmodule : bio_alu

// File: rtl/bio_exec.sv
`timescale 1ns/10ps
// Notes on behaviour
// - jump loads its eleven-bit immediate into program counter bits 10..0.
// - jump fills program counter bits above with page latch bits 4..3.
// - jump takes two instruction cycles though it is one word.
// - increments write result to accumulator when dest bit 0, file when 1.
// - increment-and-skip discards the prefetched next instruction when result is zero.
// - discarded instruction is replaced by a no-operation cycle, giving two cycles.
// - plain increment updates zero flag, takes one cycle, never skips.
// - or-literal ORs accumulator with the eight-bit immediate.
// - or-literal result goes to accumulator, updates zero flag, one cycle.
module bio_exec #(
  parameter int CYCLE_CLKS = bio_pkg::CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic reset,
  output logic [bio_pkg::PC_W-1:0] progAddr,
  input wire logic [bio_pkg::INSTR_W-1:0] progData,
  input wire logic [7:0] programPageLatch,
  output logic [bio_pkg::FADDR_W-1:0] fileRdAddr,
  input wire logic [bio_pkg::DATA_W-1:0] fileRdData,
  output bio_pkg::bio_file_write_t fileWrite,
  output logic [bio_pkg::DATA_W-1:0] accumulator,
  output logic zeroFlag,
  output logic cycleTick,
  output bio_pkg::bio_events_t events
);

  localparam int CNT_W = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLKS - 1);

  function automatic bio_pkg::bio_decoded_t decode(input logic [bio_pkg::INSTR_W-1:0] word);
    bio_pkg::bio_decoded_t d;
    d.op = bio_pkg::BIO_OP_NOP;
    d.toFile = word[bio_pkg::DEST_BIT];
    d.fileAddr = word[bio_pkg::FADDR_W-1:0];
    d.literal = word[bio_pkg::DATA_W-1:0];
    d.target = word[bio_pkg::JUMP_IMM_W-1:0];
    if (word[13:11] == bio_pkg::OPC_JUMP) begin
      d.op = bio_pkg::BIO_OP_JUMP;
    end else if (word[13:8] == bio_pkg::OPC_INC_SKIP) begin
      d.op = bio_pkg::BIO_OP_INC_SKIP;
    end else if (word[13:8] == bio_pkg::OPC_INC) begin
      d.op = bio_pkg::BIO_OP_INC;
    end else if (word[13:8] == bio_pkg::OPC_OR_LIT) begin
      d.op = bio_pkg::BIO_OP_OR_LIT;
    end
    return d;
  endfunction : decode

  function automatic logic isIncrement(input bio_pkg::bio_op_t op);
    return (op == bio_pkg::BIO_OP_INC_SKIP) || (op == bio_pkg::BIO_OP_INC);
  endfunction : isIncrement

  // instruction cycle divider
  logic [CNT_W-1:0] div_reg;
  logic [CNT_W-1:0] div_next;
  logic tick;

  always_comb begin
    tick = (div_reg == CNT_LAST);
    div_next = tick ? '0 : div_reg + CNT_W'(1);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign cycleTick = tick;

  // execute stage state
  bio_pkg::bio_exec_state_t state_reg;
  bio_pkg::bio_exec_state_t state_next;
  logic [bio_pkg::INSTR_W-1:0] instr_reg;
  logic [bio_pkg::INSTR_W-1:0] instr_next;
  logic [bio_pkg::PC_W-1:0] pc_reg;
  logic [bio_pkg::PC_W-1:0] pc_next;
  logic [bio_pkg::DATA_W-1:0] acc_reg;
  logic [bio_pkg::DATA_W-1:0] acc_next;
  logic zero_reg;
  logic zero_next;
  bio_pkg::bio_file_write_t wr_reg;
  bio_pkg::bio_file_write_t wr_next;
  bio_pkg::bio_events_t ev_reg;
  bio_pkg::bio_events_t ev_next;

  bio_pkg::bio_decoded_t dec;
  logic [bio_pkg::DATA_W-1:0] aluResult;
  logic aluZero;
  logic active;
  logic flush;
  logic [bio_pkg::DATA_W-1:0] fileOperand;

  // only a full stage executes; an empty or bubble stage is a no-operation cycle
  assign active = (state_reg == bio_pkg::BIO_EX_FULL);
  assign dec = decode(instr_reg);

  // forward a file write still in flight: with one clock per cycle the
  // next increment would otherwise read the register before it is written
  always_comb begin
    if (isIncrement(dec.op) && wr_reg.en && wr_reg.addr == dec.fileAddr) begin
      fileOperand = wr_reg.data;
    end else begin
      fileOperand = fileRdData;
    end
  end

  bio_alu u_alu (
    .op(dec.op),
    .fileData(fileOperand),
    .acc(acc_reg),
    .literal(dec.literal),
    .result(aluResult),
    .isZero(aluZero)
  );

  // retire group: working register, zero flag, file write and event pulses
  always_comb begin
    acc_next = acc_reg;
    zero_next = zero_reg;
    wr_next = '0;
    ev_next = '0;
    flush = 1'b0;
    if (tick && active) begin
      ev_next.executed = 1'b1;
      case (dec.op)
        bio_pkg::BIO_OP_JUMP: begin
          // second cycle comes from discarding the word fetched behind the jump
          flush = 1'b1;
          ev_next.jumped = 1'b1;
        end
        bio_pkg::BIO_OP_INC_SKIP: begin
          flush = aluZero;
          ev_next.skipped = aluZero;
        end
        bio_pkg::BIO_OP_INC: begin
          zero_next = aluZero;
        end
        bio_pkg::BIO_OP_OR_LIT: begin
          acc_next = aluResult;
          zero_next = aluZero;
        end
        default: begin
          // unknown opcodes retire as a no-operation
        end
      endcase
      if (isIncrement(dec.op)) begin
        if (dec.toFile) begin
          wr_next.en = 1'b1;
          wr_next.addr = dec.fileAddr;
          wr_next.data = aluResult;
        end else begin
          acc_next = aluResult;
        end
      end
    end else if (tick && state_reg == bio_pkg::BIO_EX_BUBBLE) begin
      ev_next.bubble = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_reg <= bio_pkg::ACC_RESET;
      zero_reg <= bio_pkg::ZERO_RESET;
      wr_reg <= '0;
      ev_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      zero_reg <= zero_next;
      wr_reg <= wr_next;
      ev_reg <= ev_next;
    end
  end

  // fetch group: program counter, the word waiting to execute and its state
  always_comb begin
    pc_next = pc_reg;
    instr_next = instr_reg;
    state_next = state_reg;
    if (tick) begin
      if (active && dec.op == bio_pkg::BIO_OP_JUMP) begin
        pc_next = {programPageLatch[bio_pkg::PAGE_HI:bio_pkg::PAGE_LO], dec.target};
      end else begin
        // wraps at thirteen bits; the page latch only enters on a jump
        pc_next = pc_reg + 13'h0001;
      end
      // the word fetched this cycle always moves into execute; a flush marks it as a bubble
      instr_next = progData;
      case (state_reg)
        bio_pkg::BIO_EX_FULL: begin
          state_next = flush ? bio_pkg::BIO_EX_BUBBLE : bio_pkg::BIO_EX_FULL;
        end
        bio_pkg::BIO_EX_EMPTY,
        bio_pkg::BIO_EX_BUBBLE: begin
          state_next = bio_pkg::BIO_EX_FULL;
        end
        default: begin
          // unused code: refill as after reset
          state_next = bio_pkg::BIO_EX_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= bio_pkg::BIO_EX_EMPTY;
      instr_reg <= '0;
      pc_reg <= bio_pkg::PC_RESET;
    end else begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      pc_reg <= pc_next;
    end
  end

  assign progAddr = pc_reg;
  assign fileRdAddr = dec.fileAddr;
  assign fileWrite = wr_reg;
  assign accumulator = acc_reg;
  assign zeroFlag = zero_reg;
  assign events = ev_reg;

endmodule : bio_exec

// File: rtl/bio_pkg.sv
package bio_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JUMP_IMM_W = 11;

  // instruction cycle length in clocks; the fetch and execute stages advance once per cycle
  localparam int CYCLE_CLKS = 4;

  // opcode fields, bits 13:8 of the word, except the jump which uses bits 13:11
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;

  localparam int DEST_BIT = 7;
  localparam int PAGE_LO = 3;
  localparam int PAGE_HI = 4;

  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    BIO_OP_NOP = 3'b000,
    BIO_OP_JUMP = 3'b001,
    BIO_OP_INC_SKIP = 3'b010,
    BIO_OP_INC = 3'b011,
    BIO_OP_OR_LIT = 3'b100
  } bio_op_t;

  typedef enum logic [1:0] {
    BIO_EX_EMPTY = 2'b00,
    BIO_EX_FULL = 2'b01,
    BIO_EX_BUBBLE = 2'b10
  } bio_exec_state_t;

  typedef struct packed {
    bio_op_t op;
    logic toFile;
    logic [FADDR_W-1:0] fileAddr;
    logic [DATA_W-1:0] literal;
    logic [JUMP_IMM_W-1:0] target;
  } bio_decoded_t;

  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bio_file_write_t;

  typedef struct packed {
    logic executed;
    logic jumped;
    logic skipped;
    logic bubble;
  } bio_events_t;

endpackage : bio_pkg
